// ==== include/fsc_pkg.sv ====
// fsc_pkg: register map, field positions and reset values of the fault status capture block
// assumes a 32-bit apb slave with one aligned word per register
package fsc_pkg;
    localparam int          FSC_ADDR_W       = 12;
    // register byte offsets
    localparam logic [11:0] FSC_OFF_MISUSE   = 12'h000;
    localparam logic [11:0] FSC_OFF_SEVERE   = 12'h004;
    localparam logic [11:0] FSC_OFF_PROT_ADR = 12'h008;
    localparam logic [11:0] FSC_OFF_BUS_ADR  = 12'h00C;
    localparam logic [11:0] FSC_OFF_AUX      = 12'h010;
    localparam logic [11:0] FSC_OFF_VALID    = 12'h014;
    localparam logic [11:0] FSC_OFF_MISUSE_C = 12'h018;
    // misuse status field positions
    localparam int          FSC_UNDEF_BIT    = 0;
    localparam int          FSC_ILLST_BIT    = 1;
    localparam int          FSC_BADRET_BIT   = 2;
    // severe status field positions
    localparam int          FSC_VECT_BIT     = 1;
    localparam int          FSC_FORCED_BIT   = 30;
    localparam int          FSC_DEBUG_BIT    = 31;
    // valid register field positions
    localparam int          FSC_PVALID_BIT   = 0;
    localparam int          FSC_BVALID_BIT   = 1;
    // reset values
    localparam logic [31:0] FSC_ZERO_WORD    = 32'h0000_0000;
    localparam logic [2:0]  FSC_ZERO3        = 3'h0;
    localparam logic [1:0]  FSC_ZERO2        = 2'h0;
    // apb access states
    typedef enum logic [0:0] {
        FSC_IDLE   = 1'b0,
        FSC_ACCESS = 1'b1
    } fsc_bus_t;
endpackage

// ==== hdl/fsc_sticky.sv ====
// fsc_sticky: a row of sticky flags, hardware sets, software clears by writing one
// assumes set pulses and clear mask are synchronous to ref_clk
`timescale 1ns/100ps
module fsc_sticky #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // set and clear
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    // state
    output logic      [WIDTH-1:0] flags
);
    // per bit: set wins over a clear in the same cycle, zero written leaves bit alone
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    flags[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flags[i] <= 1'b1;
                end else if (clr_in[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// ==== hdl/fsc_addr_hold.sv ====
// fsc_addr_hold: one fault address word with its valid flag
// assumes capture is a one-cycle pulse; software may overwrite the word
`timescale 1ns/100ps
module fsc_addr_hold (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // hardware capture
    input  wire logic        cap_in,
    input  wire logic [31:0] cap_addr,
    // software access
    input  wire logic        sw_wr,
    input  wire logic [31:0] sw_data,
    input  wire logic        sw_clr_valid,
    // state
    output logic      [31:0] addr_reg,
    output logic             valid_reg
);
    import fsc_pkg::*;
    // address word: a newer fault overwrites, capture beats a software write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_reg <= FSC_ZERO_WORD;
        end else if (cap_in) begin
            addr_reg <= cap_addr;
        end else if (sw_wr) begin
            addr_reg <= sw_data;
        end
    end
    // valid flag: set on capture, cleared by writing one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
        end else if (cap_in) begin
            valid_reg <= 1'b1;
        end else if (sw_clr_valid) begin
            valid_reg <= 1'b0;
        end
    end
endmodule

// ==== hdl/fsc_top.sv ====
// fsc_top: fault status and fault address registers behind an apb slave
// assumes fault events arrive as one-cycle pulses from the core's fault detection
`timescale 1ns/100ps
module fsc_top #(
    parameter int AUX_W = 32
) (
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [fsc_pkg::FSC_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // misuse fault events
    input  wire logic                              bad_return_load_ev,
    input  wire logic                              illegal_state_ev,
    input  wire logic                              undecodable_op_ev,
    // severe fault events
    input  wire logic                              forced_escalation_ev,
    input  wire logic                              vector_fetch_error_ev,
    // protection fault address capture
    input  wire logic                              prot_fault_ev,
    input  wire logic [31:0]                       prot_fault_addr,
    // bus fault address capture
    input  wire logic                              exact_data_error_ev,
    input  wire logic [31:0]                       bus_request_addr,
    // auxiliary event inputs
    input  wire logic [AUX_W-1:0]                  aux_event_inputs,
    // status to the core
    output logic      [2:0]                        misuse_flags_out,
    output logic      [1:0]                        addr_valid_out
);
    import fsc_pkg::*;

    fsc_bus_t          bus_state_reg;
    logic              wr_en;
    logic              rd_en;
    logic              hit;
    logic [31:0]       rd_next;
    logic [31:0]       wmask;
    logic [2:0]        misuse_set;
    logic [2:0]        misuse_clr;
    logic [2:0]        misuse_flags;
    logic [31:0]       severe_set;
    logic [31:0]       severe_clr;
    logic [31:0]       severe_flags;
    logic [AUX_W-1:0]  aux_clr;
    logic [AUX_W-1:0]  aux_flags;
    logic [31:0]       prot_addr;
    logic              prot_valid;
    logic [31:0]       bus_addr;
    logic              bus_valid;

    // byte lane expansion of the write strobes
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // address decode, shared by read and write paths
    function automatic logic is_mapped(input logic [FSC_ADDR_W-1:0] a);
        is_mapped = (a == FSC_OFF_MISUSE) || (a == FSC_OFF_SEVERE) || (a == FSC_OFF_PROT_ADR) ||
                    (a == FSC_OFF_BUS_ADR) || (a == FSC_OFF_AUX) || (a == FSC_OFF_VALID) ||
                    (a == FSC_OFF_MISUSE_C);
    endfunction

    // access phase strobes; the slave answers in the first access cycle
    assign wr_en = psel && penable && pwrite && (bus_state_reg == FSC_ACCESS);
    assign rd_en = psel && penable && !pwrite && (bus_state_reg == FSC_ACCESS);
    assign hit   = is_mapped(paddr);
    assign wmask = lane_mask(pstrb) & pwdata;

    // apb phase tracker
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_state_reg <= FSC_IDLE;
        end else begin
            unique case (bus_state_reg)
                FSC_IDLE: begin
                    if (psel && !penable) begin
                        bus_state_reg <= FSC_ACCESS;
                    end
                end
                FSC_ACCESS: begin
                    bus_state_reg <= FSC_IDLE;
                end
            endcase
        end
    end

    // misuse event conditioning
    always_comb begin
        misuse_set                 = FSC_ZERO3;
        misuse_set[FSC_BADRET_BIT] = bad_return_load_ev;
        misuse_set[FSC_ILLST_BIT]  = illegal_state_ev && !undecodable_op_ev;
        misuse_set[FSC_UNDEF_BIT]  = undecodable_op_ev;
    end

    // write-one-to-clear masks; the mirror offset clears misuse bits too
    assign misuse_clr = (wr_en && (paddr == FSC_OFF_MISUSE || paddr == FSC_OFF_MISUSE_C))
                        ? wmask[2:0] : FSC_ZERO3;
    assign severe_clr = (wr_en && paddr == FSC_OFF_SEVERE) ? wmask : FSC_ZERO_WORD;
    assign aux_clr    = (wr_en && paddr == FSC_OFF_AUX) ? wmask[AUX_W-1:0] : '0;

    // severe events; bit 31 has no hardware source here
    always_comb begin
        severe_set                 = FSC_ZERO_WORD;
        severe_set[FSC_FORCED_BIT] = forced_escalation_ev;
        severe_set[FSC_VECT_BIT]   = vector_fetch_error_ev;
    end

    // misuse flags
    fsc_sticky #(
        .WIDTH (3)
    ) u_misuse (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_in  (misuse_set),
        .clr_in  (misuse_clr),
        .flags   (misuse_flags)
    );

    // severe flags
    fsc_sticky #(
        .WIDTH (32)
    ) u_severe (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_in  (severe_set),
        .clr_in  (severe_clr),
        .flags   (severe_flags)
    );

    // auxiliary flags; no exception is raised from them
    fsc_sticky #(
        .WIDTH (AUX_W)
    ) u_aux (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_in  (aux_event_inputs),
        .clr_in  (aux_clr),
        .flags   (aux_flags)
    );

    // protection fault address: actual faulting address as given by the core
    fsc_addr_hold u_prot (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .cap_in       (prot_fault_ev),
        .cap_addr     (prot_fault_addr),
        .sw_wr        (wr_en && paddr == FSC_OFF_PROT_ADR),
        .sw_data      (pwdata),
        .sw_clr_valid (wr_en && paddr == FSC_OFF_VALID && wmask[FSC_PVALID_BIT]),
        .addr_reg     (prot_addr),
        .valid_reg    (prot_valid)
    );

    // bus fault address: instruction's requested address on an exact data error
    fsc_addr_hold u_bus (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .cap_in       (exact_data_error_ev),
        .cap_addr     (bus_request_addr),
        .sw_wr        (wr_en && paddr == FSC_OFF_BUS_ADR),
        .sw_data      (pwdata),
        .sw_clr_valid (wr_en && paddr == FSC_OFF_VALID && wmask[FSC_BVALID_BIT]),
        .addr_reg     (bus_addr),
        .valid_reg    (bus_valid)
    );

    // read mux
    always_comb begin
        rd_next = FSC_ZERO_WORD;
        unique case (paddr)
            FSC_OFF_MISUSE:   rd_next[2:0]       = misuse_flags;
            FSC_OFF_MISUSE_C: rd_next[2:0]       = misuse_flags;
            FSC_OFF_SEVERE:   rd_next            = severe_flags;
            FSC_OFF_PROT_ADR: rd_next            = prot_addr;
            FSC_OFF_BUS_ADR:  rd_next            = bus_addr;
            FSC_OFF_AUX:      rd_next[AUX_W-1:0] = aux_flags;
            FSC_OFF_VALID:    rd_next[1:0]       = {bus_valid, prot_valid};
            default:          rd_next            = FSC_ZERO_WORD;
        endcase
    end

    // apb answer registers: ready in the first cycle of the access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= FSC_ZERO_WORD;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;  // unmapped offset answers with an error
            prdata  <= (psel && !penable && !pwrite) ? rd_next : FSC_ZERO_WORD;
        end
    end

    // status copies for the core
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            misuse_flags_out <= FSC_ZERO3;
            addr_valid_out   <= FSC_ZERO2;
        end else begin
            misuse_flags_out <= misuse_flags;
            addr_valid_out   <= {bus_valid, prot_valid};
        end
    end
endmodule

// ==== sim/fsc_checker.sv ====
// fsc_checker: port-level assertions on the fault status block
// assumes it is bound into fsc_top and sees only its ports
`timescale 1ns/100ps
module fsc_checker (
    // clock and reset
    input wire logic                           ref_clk,
    input wire logic                           rst,
    // apb
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [fsc_pkg::FSC_ADDR_W-1:0] paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    // events and status
    input wire logic                           bad_return_load_ev,
    input wire logic                           illegal_state_ev,
    input wire logic                           undecodable_op_ev,
    input wire logic                           prot_fault_ev,
    input wire logic                           exact_data_error_ev,
    input wire logic [2:0]                     misuse_flags_out,
    input wire logic [1:0]                     addr_valid_out
);
    import fsc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // completed write to the misuse register
    logic clr_w;
    assign clr_w = psel && penable && pready && pwrite && (paddr == FSC_OFF_MISUSE || paddr == FSC_OFF_MISUSE_C);
    // bus answer timing
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |-> $past(psel && !penable) ##1 !pready) else $error("bad pready");
    a_err_unmapped: assert property (psel && !penable |=>
        pslverr == !($past(paddr) <= FSC_OFF_MISUSE_C && $past(paddr[1:0]) == 2'b00))
        else $error("pslverr wrong");
    a_rdata_idle_zero: assert property (!pready |-> prdata == FSC_ZERO_WORD) else $error("prdata not zero");
    // misuse flags follow their events
    a_badret_flag_set: assert property (bad_return_load_ev |-> ##2 misuse_flags_out[FSC_BADRET_BIT])
        else $error("bad return flag missing");
    a_undef_flag_set: assert property (undecodable_op_ev |-> ##2 misuse_flags_out[FSC_UNDEF_BIT])
        else $error("undecodable flag missing");
    a_illst_flag_cause: assert property ($rose(misuse_flags_out[FSC_ILLST_BIT]) |->
        $past(illegal_state_ev && !undecodable_op_ev, 2)) else $error("illegal state flag without cause");
    a_misuse_flag_sticky: assert property (|($past(misuse_flags_out) & ~misuse_flags_out) |->
        $past(clr_w, 2)) else $error("misuse flag dropped without clear");
    // address valid flags follow captures
    a_prot_valid_set: assert property (prot_fault_ev |-> ##2 addr_valid_out[FSC_PVALID_BIT])
        else $error("prot valid missing");
    a_bus_valid_set: assert property (exact_data_error_ev |-> ##2 addr_valid_out[FSC_BVALID_BIT])
        else $error("bus valid missing");
endmodule

bind fsc_top fsc_checker u_chk (.*);

// ==== sim/fsc_evt_src.sv ====
// fsc_evt_src: stands in for the core's fault detection logic
// assumes the bench raises go for one cycle per burst of events
`timescale 1ns/100ps
module fsc_evt_src (
    // clock
    input  wire logic        ref_clk,
    // request from the bench
    input  wire logic        go,
    input  wire logic [6:0]  kind,
    input  wire logic [31:0] adr,
    input  wire logic [31:0] aux,
    // pulses to the block
    output logic      [6:0]  ev,
    output logic      [31:0] ev_adr,
    output logic      [31:0] ev_aux
);
    // event lines pulse for one cycle only
    always_ff @(posedge ref_clk) begin
        ev     <= go ? kind : 7'h00;
        ev_aux <= go ? aux : 32'h0000_0000;
    end
    // the address is not held once the pulse is over
    always_ff @(posedge ref_clk) begin
        ev_adr <= go ? adr : ~adr;
    end
endmodule

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the fault status block over apb
// assumes fsc_top, fsc_evt_src and the bound checker are compiled first
`timescale 1ns/100ps
module tb_top;
    import fsc_pkg::*;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, adr, aux, ev_adr, ev_aux, m, c;
    logic [6:0]  kind, ev;
    logic [3:0]  pstrb;
    logic [2:0]  mis;
    logic [1:0]  vld;
    logic [32:0] exp_q[$];
    string       nm_q[$];
    int          errors, tests_run, cyc;
    fsc_evt_src u_src (.*);
    fsc_top u_dut (.*, .bad_return_load_ev(ev[0]), .illegal_state_ev(ev[1]), .undecodable_op_ev(ev[2]),
        .forced_escalation_ev(ev[3]), .vector_fetch_error_ev(ev[4]), .prot_fault_ev(ev[5]),
        .prot_fault_addr(ev_adr), .exact_data_error_ev(ev[6]), .bus_request_addr(ev_adr),
        .aux_event_inputs(ev_aux), .misuse_flags_out(mis), .addr_valid_out(vld));
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // one apb transfer, request held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
    endtask
    // read with its expected answer noted
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        apb(1'b0, a, 32'h0);
    endtask
    // fault events through the partner
    task automatic fire(input logic [6:0] k, input logic [31:0] a, input logic [31:0] x);
        psel <= 1'b0;
        penable <= 1'b0;
        kind <= k;
        adr <= a;
        aux <= x;
        go <= 1'b1;
        @(posedge ref_clk) go <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic fin(input string n);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        $display("test %s done", n);
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // compare each completed read with the oldest note
    always @(posedge ref_clk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            tests_run++;
            if ({pslverr, prdata} !== exp_q[0]) begin
                errors++;
                $display("ERROR %s expected %h seen %h", nm_q[0], exp_q[0], {pslverr, prdata});
            end
            void'(exp_q.pop_front());
            void'(nm_q.pop_front());
        end
        if (cyc == 3000) begin
            errors++;
            test_done();
        end
    end
    // main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, go, paddr, pwdata, kind, adr, aux} = '0;
        pstrb = 4'hF;
        void'($urandom(32'hB1F6));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i <= 7; i++) rd(12'(i * 4), {i == 7, FSC_ZERO_WORD}, "reset");
        m = $urandom();
        apb(1'b1, FSC_OFF_PROT_ADR, m);
        apb(1'b1, FSC_OFF_BUS_ADR, ~m);
        rd(FSC_OFF_PROT_ADR, {1'b0, m}, "prot_adr");
        rd(FSC_OFF_BUS_ADR, {1'b0, ~m}, "bus_adr");
        fin("reset");
        for (int i = 0; i < 3; i++) begin
            c = 32'h1 << (2 - i);
            fire(7'(1 << i), 32'h0, 32'h0);
            apb(1'b1, FSC_OFF_MISUSE, ~c);
            rd(FSC_OFF_MISUSE, {1'b0, c}, "misuse");
            rd(FSC_OFF_MISUSE_C, {1'b0, c}, "misuse_mirror");
            apb(1'b1, FSC_OFF_MISUSE, c);
            rd(FSC_OFF_MISUSE, 33'h0, "misuse_clr");
        end
        fire(7'h06, 32'h0, 32'h0);
        rd(FSC_OFF_MISUSE, 33'h1, "undef_only");
        apb(1'b1, FSC_OFF_MISUSE_C, 32'h1);
        rd(FSC_OFF_MISUSE, 33'h0, "mirror_clr");
        fin("misuse");
        fire(7'h08, 32'h0, 32'h0);
        fire(7'h10, 32'h0, 32'h0);
        rd(FSC_OFF_SEVERE, {1'b0, 32'h4000_0002}, "severe");
        apb(1'b1, FSC_OFF_SEVERE, 32'h0000_0002);
        rd(FSC_OFF_SEVERE, {1'b0, 32'h4000_0000}, "severe_clr");
        apb(1'b1, FSC_OFF_SEVERE, 32'h4000_0000);
        rd(FSC_OFF_SEVERE, 33'h0, "severe_clr");
        fin("severe");
        m = $urandom();
        c = $urandom();
        fire(7'h20, m, 32'h0);
        rd(FSC_OFF_PROT_ADR, {1'b0, m}, "prot_adr");
        rd(FSC_OFF_VALID, 33'h1, "valid");
        fire(7'h40, c, 32'h0);
        rd(FSC_OFF_BUS_ADR, {1'b0, c}, "bus_adr");
        rd(FSC_OFF_PROT_ADR, {1'b0, m}, "prot_keep");
        rd(FSC_OFF_VALID, 33'h3, "valid");
        apb(1'b1, FSC_OFF_VALID, 32'h3);
        rd(FSC_OFF_VALID, 33'h0, "valid_clr");
        fin("address");
        m = $urandom();
        c = $urandom();
        fire(7'h00, 32'h0, m);
        rd(FSC_OFF_AUX, {1'b0, m}, "aux");
        apb(1'b1, FSC_OFF_AUX, c);
        rd(FSC_OFF_AUX, {1'b0, m & ~c}, "aux_part");
        rd(FSC_OFF_SEVERE, 33'h0, "no_exception");
        pstrb <= 4'h1;
        apb(1'b1, FSC_OFF_AUX, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rd(FSC_OFF_AUX, {1'b0, m & ~c & 32'hFFFF_FF00}, "aux_lane");
        apb(1'b1, FSC_OFF_AUX, 32'hFFFF_FFFF);
        rd(FSC_OFF_AUX, 33'h0, "aux_clr");
        fin("aux");
        test_done();
    end
endmodule
